// *** design/vps_pkg.sv ***
// shared constants and types for the velocity pwm amplitude scaler
package vps_pkg;
  // ----------------------------------------------------------------
  // register map, one aligned 32-bit word each
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SCALE = 8'h04;
  localparam logic [7:0] OFS_THRESH = 8'h08;
  localparam logic [7:0] OFS_INTERVAL = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_INT_STAT = 8'h14;
  localparam logic [7:0] OFS_INT_MASK = 8'h18;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_AUTO = 0;
  localparam int CTRL_QEN = 1;
  localparam int GRAD_LSB = 8;
  localparam int STAT_QUIET = 8;
  localparam int STAT_OLA = 9;
  localparam int STAT_OLB = 10;
  localparam int INT_OLA = 0;
  localparam int INT_OLB = 1;
  localparam int INT_MODE = 2;
  localparam int INT_W = 3;
  // ----------------------------------------------------------------
  // widths, limits and reset values
  // ----------------------------------------------------------------
  localparam int STEP_W = 20;
  localparam logic [STEP_W-1:0] STEP_MAX = 20'hfffff;
  localparam logic [STEP_W-1:0] STEP_ONE = 20'h00001;
  localparam logic [7:0] AMP_MAX = 8'hff;
  localparam logic [7:0] SCALE_LOW_BYTE = 8'h00;
  localparam logic [7:0] OFFSET_RST = 8'hff;
  localparam logic [7:0] GRAD_RST = 8'h04;
  localparam int PWM_DIV = 1024;
  localparam int PWM_CNT_W = 10;
  localparam logic [PWM_CNT_W-1:0] PWM_LAST = PWM_CNT_W'(PWM_DIV - 1);
  localparam int USTEPS_PER_FULL = 256;
  localparam int OL_WINDOW_FULL = 4;
  localparam int MISS_W = 11;
  localparam logic [MISS_W-1:0] MISS_LIMIT = MISS_W'(OL_WINDOW_FULL * USTEPS_PER_FULL);
  localparam int DIV_QW = 16;
  localparam logic [4:0] DIV_LAST = 5'(DIV_QW - 1);
  // ----------------------------------------------------------------
  // divider sequencer
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    VPS_DIV_IDLE = 1'b0,
    VPS_DIV_RUN = 1'b1
  } vps_div_state_t;
endpackage

// *** design/vps_div_if.sv ***
// request and answer bundle between the scaler and its divider
`timescale 1ns/1ps
interface vps_div_if;
  import vps_pkg::*;
  logic start;
  logic [DIV_QW-1:0] dividend;
  logic [STEP_W-1:0] divisor;
  logic busy;
  logic done;
  logic [DIV_QW-1:0] quotient;
  modport req (output start, output dividend, output divisor,
               input busy, input done, input quotient);
  modport calc (input start, input dividend, input divisor,
                output busy, output done, output quotient);
endinterface

// *** design/vps_div_core.sv ***
// sequential restoring divider: gradient*256 over the step interval
`timescale 1ns/1ps
module vps_div_core
  import vps_pkg::*;
(
  input wire logic pclk,      // driver clock
  input wire logic presetn,   // async reset, active low
  vps_div_if.calc div         // request and quotient
);
  typedef struct packed {
    vps_div_state_t state;
    logic [4:0] cnt;
    logic [STEP_W:0] rem;
    logic [STEP_W-1:0] dsr;
    logic [DIV_QW-1:0] q;
    logic done;
  } vps_div_reg_t;

  vps_div_reg_t s;
  vps_div_reg_t next_s;
  logic [STEP_W:0] trial;

  // ----------------------------------------------------------------
  // one quotient bit per cycle keeps the area to one subtractor
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    trial = {s.rem[STEP_W-1:0], s.q[DIV_QW-1]};
    case (s.state)
      VPS_DIV_IDLE: begin
        if (div.start) begin
          next_s.q = div.dividend;
          next_s.rem = '0;
          next_s.dsr = div.divisor;
          next_s.cnt = DIV_LAST;
          next_s.state = VPS_DIV_RUN;
        end
      end
      VPS_DIV_RUN: begin
        // a zero divisor yields all ones, which the caller saturates
        if (trial >= {1'b0, s.dsr}) begin
          next_s.rem = trial - {1'b0, s.dsr};
          next_s.q = {s.q[DIV_QW-2:0], 1'b1};
        end else begin
          next_s.rem = trial;
          next_s.q = {s.q[DIV_QW-2:0], 1'b0};
        end
        if (s.cnt == '0) begin
          next_s.state = VPS_DIV_IDLE;
          next_s.done = 1'b1;
        end else begin
          next_s.cnt = s.cnt - 5'h01;
        end
      end
      default: next_s.state = VPS_DIV_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // answers come straight from the registers
  assign div.busy = (s.state == VPS_DIV_RUN);
  assign div.done = s.done;
  assign div.quotient = s.q;
endmodule

// *** design/vps_amp_scaler.sv ***
// quiet-mode pwm amplitude scaler with mode switch, open-load flags, apb
//
// Operation
// - without autoscale, amplitude follows measured step interval, not current.
// - velocity amplitude = offset + gradient*256*fstep/fclk.
// - amplitude is 8 bits against a 248-peak sine; coil voltage = vm*amp/374.
// - threshold picks quiet or other chopper; zero threshold keeps quiet always.
// - in the other chopper the amplitude is held and resumed on return.
// - per-coil open-load flag shows whether nominal current is reachable.
// - an open coil gives a steady flag; an intact one may flicker.
// - both flags set when target not reached within last few full steps.
// - with autoscale the live amplitude is readable for load evaluation.
// - quiet mode holds only while step interval is at or above threshold.
// - autoscale set selects current regulation, clear selects velocity scaling.
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ps
module vps_amp_scaler
  import vps_pkg::*;
#(
  parameter int PWM_PERIOD = PWM_DIV      // clocks per chopper period
)
(
  input wire logic pclk,                  // driver clock, 100 MHz
  input wire logic presetn,               // async reset, active low
  input wire logic psel,                  // apb select
  input wire logic penable,               // apb access phase
  input wire logic pwrite,                // apb write
  input wire logic [ADDR_W-1:0] paddr,    // apb byte address
  input wire logic [31:0] pwdata,         // apb write data
  output logic [31:0] prdata,             // apb read data
  output logic pready,                    // apb ready
  output logic pslverr,                   // apb error, unmapped address
  input wire logic step,                  // microstep pulse pin
  input wire logic coil_a_below,          // coil a current below target
  input wire logic coil_b_below,          // coil b current below target
  output logic [7:0] amplitude,           // applied pwm amplitude
  output logic quiet_active,              // quiet pwm mode in use
  output logic open_load_coil_a,          // open-load flag coil a
  output logic open_load_coil_b,          // open-load flag coil b
  output logic irq                        // interrupt, active high level
);
  typedef struct packed {
    logic [2:0] step_sync;
    logic [1:0] a_sync;
    logic [1:0] b_sync;
    logic [STEP_W-1:0] interval_cnt;
    logic [STEP_W-1:0] step_interval;
    logic auto_en;
    logic quiet_en;
    logic [7:0] offset;
    logic [7:0] gradient;
    logic [STEP_W-1:0] threshold;
    logic [7:0] amplitude;
    logic quiet_active;
    logic reg_started;
    logic [PWM_CNT_W-1:0] pwm_cnt;
    logic pwm_tick;
    logic ol_a;
    logic ol_b;
    logic [MISS_W-1:0] miss_cnt;
    logic [INT_W-1:0] int_stat;
    logic [INT_W-1:0] int_mask;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic div_start;
  } vps_state_t;

  // last count of the chopper period divider; the counter width caps the period at 1024
  localparam logic [PWM_CNT_W-1:0] PERIOD_LAST = PWM_CNT_W'(PWM_PERIOD - 1);

  vps_state_t s;
  vps_state_t next_s;
  logic step_edge;
  logic a_low;
  logic b_low;
  logic [16:0] vel_sum;
  logic [8:0] amp_up;
  logic apb_hit;
  logic commit;
  logic [INT_W-1:0] w1c;
  logic [INT_W-1:0] ev;

  vps_div_if div ();

  // ----------------------------------------------------------------
  // divider for the velocity term
  // ----------------------------------------------------------------
  vps_div_core u_div (
    .pclk(pclk),
    .presetn(presetn),
    .div(div)
  );

  // velocity term is gradient*256 over the interval in clock cycles
  assign div.start = s.div_start;
  assign div.dividend = {s.gradient, SCALE_LOW_BYTE};
  assign div.divisor = s.step_interval;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    step_edge = s.step_sync[1] & ~s.step_sync[2];
    a_low = s.a_sync[1];
    b_low = s.b_sync[1];
    vel_sum = {9'h000, s.offset} + {1'b0, div.quotient};
    amp_up = {1'b0, s.amplitude} + {1'b0, s.gradient};
    apb_hit = psel & penable;
    commit = apb_hit & s.pready;
    w1c = '0;

    // pins pass two flops; coil logic uses the second stage, the step edge uses the second and a third
    next_s.step_sync = {s.step_sync[1:0], step};
    next_s.a_sync = {s.a_sync[0], coil_a_below};
    next_s.b_sync = {s.b_sync[0], coil_b_below};

    // interval between microsteps; saturation marks standstill
    if (step_edge) begin
      next_s.step_interval = s.interval_cnt;
      next_s.interval_cnt = STEP_ONE;
    end else if (s.interval_cnt != STEP_MAX) begin
      next_s.interval_cnt = s.interval_cnt + STEP_ONE;
    end else begin
      next_s.step_interval = STEP_MAX;
    end

    // chopper period enable from the clock divider
    next_s.pwm_tick = (s.pwm_cnt == PERIOD_LAST);
    next_s.pwm_cnt = next_s.pwm_tick ? '0 : s.pwm_cnt + 1'b1;

    // mode choice: long interval means low velocity
    next_s.quiet_active = s.quiet_en &&
      (s.threshold == '0 || s.step_interval >= s.threshold);

    // regulation only starts once standstill has been seen
    if (!(s.quiet_en && s.auto_en)) begin
      next_s.reg_started = 1'b0;
    end else if (s.step_interval == STEP_MAX) begin
      next_s.reg_started = 1'b1;
    end

    // keep the divider recomputing back to back
    next_s.div_start = !s.div_start && !div.busy;

    // amplitude update; outside quiet mode nothing changes it
    if (s.quiet_active) begin
      if (!s.auto_en) begin
        if (div.done) begin
          // clipping avoids a wrap to a tiny amplitude at speed
          next_s.amplitude = (vel_sum > {9'h000, AMP_MAX}) ? AMP_MAX
                                                         : vel_sum[7:0];
        end
      end else if (s.reg_started && s.pwm_tick) begin
        if (a_low || b_low) begin
          next_s.amplitude = amp_up[8] ? AMP_MAX : amp_up[7:0];
        end else if (s.amplitude != '0) begin
          next_s.amplitude = s.amplitude - 8'h01;
        end
      end
    end

    // open-load evaluation, quiet mode only
    if (s.quiet_active) begin
      if (!(a_low || b_low)) begin
        next_s.miss_cnt = '0;
      end else if (step_edge && s.miss_cnt != MISS_LIMIT) begin
        next_s.miss_cnt = s.miss_cnt + 1'b1;
      end
      if (s.pwm_tick) begin
        // open coil stays low even at full drive, so its flag stays up
        next_s.ol_a = a_low && (s.amplitude == AMP_MAX);
        next_s.ol_b = b_low && (s.amplitude == AMP_MAX);
      end
      if (s.miss_cnt == MISS_LIMIT) begin
        next_s.ol_a = 1'b1;
        next_s.ol_b = 1'b1;
      end
    end

    // apb: one wait state, answer registered
    next_s.pready = apb_hit & ~s.pready;
    if (apb_hit && !s.pready) begin
      next_s.prdata = '0;
      next_s.pslverr = 1'b0;
      case (paddr)
        OFS_CTRL: begin
          next_s.prdata[CTRL_AUTO] = s.auto_en;
          next_s.prdata[CTRL_QEN] = s.quiet_en;
        end
        OFS_SCALE: begin
          next_s.prdata[7:0] = s.offset;
          next_s.prdata[GRAD_LSB +: 8] = s.gradient;
        end
        OFS_THRESH: next_s.prdata[STEP_W-1:0] = s.threshold;
        OFS_INTERVAL: next_s.prdata[STEP_W-1:0] = s.step_interval;
        OFS_STATUS: begin
          next_s.prdata[7:0] = s.amplitude;
          next_s.prdata[STAT_QUIET] = s.quiet_active;
          next_s.prdata[STAT_OLA] = s.ol_a;
          next_s.prdata[STAT_OLB] = s.ol_b;
        end
        OFS_INT_STAT: next_s.prdata[INT_W-1:0] = s.int_stat;
        OFS_INT_MASK: next_s.prdata[INT_W-1:0] = s.int_mask;
        default: next_s.pslverr = 1'b1;
      endcase
    end
    if (commit) begin
      next_s.pslverr = 1'b0;
    end

    // writes land at the edge that completes the access
    if (commit && pwrite) begin
      case (paddr)
        OFS_CTRL: begin
          next_s.auto_en = pwdata[CTRL_AUTO];
          next_s.quiet_en = pwdata[CTRL_QEN];
        end
        OFS_SCALE: begin
          next_s.offset = pwdata[7:0];
          next_s.gradient = pwdata[GRAD_LSB +: 8];
        end
        OFS_THRESH: next_s.threshold = pwdata[STEP_W-1:0];
        OFS_INT_STAT: w1c = pwdata[INT_W-1:0];
        OFS_INT_MASK: next_s.int_mask = pwdata[INT_W-1:0];
        default: w1c = '0;
      endcase
    end

    // sticky events; a new event beats a same-cycle clear
    ev = '0;
    ev[INT_OLA] = next_s.ol_a & ~s.ol_a;
    ev[INT_OLB] = next_s.ol_b & ~s.ol_b;
    ev[INT_MODE] = next_s.quiet_active ^ s.quiet_active;
    next_s.int_stat = (s.int_stat & ~w1c) | ev;
    next_s.irq = |(next_s.int_stat & next_s.int_mask);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.offset <= OFFSET_RST;
      s.gradient <= GRAD_RST;
      s.interval_cnt <= STEP_MAX;
      s.step_interval <= STEP_MAX;
    end else begin
      s <= next_s;
    end
  end

  // outputs come straight from the state flops
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign amplitude = s.amplitude;
  assign quiet_active = s.quiet_active;
  assign open_load_coil_a = s.ol_a;
  assign open_load_coil_b = s.ol_b;
  assign irq = s.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_div_request;
    div.start && !div.busy;
  endsequence

  sequence s_div_answer;
    ##[16:18] div.done;
  endsequence

  a_div_answers: assert property (s_div_request |-> s_div_answer)
    else $error("divider did not answer in time");

  a_quiet_zero_thr: assert property (
    s.quiet_en && s.threshold == '0 |=> quiet_active)
    else $error("zero threshold left quiet mode");

  a_quiet_fast_off: assert property (
    s.quiet_en && s.threshold != '0 && s.step_interval < s.threshold
    |=> !quiet_active)
    else $error("quiet mode kept above threshold velocity");

  a_amp_hold_fast: assert property (
    !s.quiet_active |=> amplitude == $past(amplitude))
    else $error("amplitude moved in other chopper mode");

  a_vel_amp_sat: assert property (
    s.quiet_active && !s.auto_en && div.done &&
    ({1'b0, div.quotient} + {9'h000, s.offset}) > 17'h000ff
    |=> amplitude == AMP_MAX)
    else $error("velocity amplitude wrapped");

  a_vel_amp_sum: assert property (
    s.quiet_active && !s.auto_en && div.done && div.quotient == '0
    |=> amplitude == $past(s.offset))
    else $error("velocity amplitude lost its offset");

  a_auto_step_down: assert property (
    s.quiet_active && s.auto_en && s.reg_started && s.pwm_tick &&
    !a_low && !b_low && s.amplitude != '0
    |=> amplitude == $past(amplitude) - 8'h01)
    else $error("regulator did not step down");

  a_auto_step_up: assert property (
    s.quiet_active && s.auto_en && s.reg_started && s.pwm_tick && (a_low || b_low) &&
    s.amplitude <= AMP_MAX - s.gradient
    |=> amplitude == $past(amplitude) + $past(s.gradient))
    else $error("regulator did not step up");

  a_ol_frozen_fast: assert property (
    !s.quiet_active |=> open_load_coil_a == $past(open_load_coil_a) &&
    open_load_coil_b == $past(open_load_coil_b))
    else $error("open-load flags moved in other chopper mode");

  a_ol_open_coil: assert property (
    s.quiet_active && s.pwm_tick && a_low && s.amplitude == AMP_MAX
    |=> open_load_coil_a)
    else $error("open coil a not flagged");

  a_ol_both_miss: assert property (
    s.quiet_active && s.miss_cnt == MISS_LIMIT
    |=> open_load_coil_a && open_load_coil_b)
    else $error("missed target did not raise both flags");

  a_sticky_set_wins: assert property (
    ev[INT_OLA] && w1c[INT_OLA] |=> s.int_stat[INT_OLA])
    else $error("event lost against clear");

  a_irq_follows: assert property (
    |(s.int_stat & s.int_mask) |-> irq)
    else $error("irq low with unmasked status");
endmodule

// *** bench/vps_step_src.sv ***
// step source and coil current sense stand-in facing the amplitude scaler
`timescale 1ns/1ps
module vps_step_src (
  input wire logic pclk,          // driver clock
  input wire logic presetn,       // async reset, active low
  input wire logic run,           // step train on
  input wire logic [15:0] period, // clocks from one step to the next
  input wire logic below_a_cmd,   // coil a cannot reach its target
  input wire logic below_b_cmd,   // coil b cannot reach its target
  output logic step,              // microstep pulse pin
  output logic coil_a_below,      // coil a current below target
  output logic coil_b_below       // coil b current below target
);
  logic [15:0] cnt;
  // ----------------------------------------------------------------
  // step train
  // ----------------------------------------------------------------
  // pin rests low at standstill; pulse stays 4 clocks so the synchroniser sees it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 16'h0000;
      step <= 1'b0;
    end else if (!run) begin
      cnt <= 16'h0000;
      step <= 1'b0;
    end else begin
      cnt <= (cnt >= period - 16'h0001) ? 16'h0000 : cnt + 16'h0001;
      step <= (cnt < 16'h0004);
    end
  end
  // comparators follow the commanded coil condition, registered like a real sampler
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      coil_a_below <= 1'b0;
      coil_b_below <= 1'b0;
    end else begin
      coil_a_below <= below_a_cmd;
      coil_b_below <= below_b_cmd;
    end
  end
endmodule

// *** bench/vps_amp_scaler_tb_top.sv ***
// self-checking bench for the velocity pwm amplitude scaler
`timescale 1ns/1ps
module vps_amp_scaler_tb_top;
  import vps_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic step;
  logic coil_a_below;
  logic coil_b_below;
  logic [7:0] amplitude;
  logic quiet_active;
  logic open_load_coil_a;
  logic open_load_coil_b;
  logic irq;
  logic run = 1'b0;
  logic [15:0] period = 16'h0100;
  logic below_a = 1'b0;
  logic below_b = 1'b0;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic err;
  // fastest chopper divider keeps the long standstill phase short
  localparam int PWM_PERIOD_TB = 410;
  // ----------------------------------------------------------------
  // clock, timeout, instances
  // ----------------------------------------------------------------
  always #5 pclk = ~pclk;
  // whole run needs about 80k cycles; the ceiling leaves margin for slow answers
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      error_cnt = error_cnt + 1;
      $display("MISMATCH at %0t: timeout", $time);
      finish_test();
    end
  end
  vps_amp_scaler #(.PWM_PERIOD(PWM_PERIOD_TB)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .step(step), .coil_a_below(coil_a_below),
    .coil_b_below(coil_b_below), .amplitude(amplitude), .quiet_active(quiet_active),
    .open_load_coil_a(open_load_coil_a), .open_load_coil_b(open_load_coil_b), .irq(irq));
  vps_step_src u_src (.pclk(pclk), .presetn(presetn), .run(run), .period(period),
    .below_a_cmd(below_a), .below_b_cmd(below_b), .step(step),
    .coil_a_below(coil_a_below), .coil_b_below(coil_b_below));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer; held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait-state count is assumed; only the bench timeout ends this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    run <= 1'b0;
    below_a <= 1'b0;
    below_b <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // reset values and an unmapped word
  task automatic t_regs();
    apb(1'b0, OFS_CTRL, 32'h0); check(rd, 32'h0);
    apb(1'b0, OFS_SCALE, 32'h0); check(rd, 32'h0000_04ff);
    apb(1'b0, OFS_THRESH, 32'h0); check(rd, 32'h0);
    apb(1'b0, OFS_INTERVAL, 32'h0); check(rd, 32'h000f_ffff);
    apb(1'b0, OFS_INT_MASK, 32'h0); check(rd, 32'h0);
    apb(1'b0, 8'h1c, 32'h0); check({31'h0, err}, 32'h1);
  endtask
  // velocity scaling, saturation, threshold switch and hold
  task automatic t_velocity();
    apb(1'b1, OFS_SCALE, 32'h0000_0410);
    // both coils pass the open-load check before quiet mode goes on
    below_a <= 1'b0;
    below_b <= 1'b0;
    apb(1'b1, OFS_CTRL, 32'h2);
    period <= 16'h0100;
    run <= 1'b1;
    repeat (1200) @(posedge pclk);
    check({24'h0, amplitude}, 32'h14);
    apb(1'b0, OFS_STATUS, 32'h0); check(rd, 32'h0000_0114);
    check({31'h0, quiet_active}, 32'h1);
    apb(1'b1, OFS_SCALE, 32'h0000_fff0);
    repeat (100) @(posedge pclk);
    check({24'h0, amplitude}, 32'hff);
    apb(1'b1, OFS_SCALE, 32'h0000_0430);
    // let the divider pick up the new gradient before quiet mode is left
    repeat (100) @(posedge pclk);
    check({24'h0, amplitude}, 32'h34);
    apb(1'b1, OFS_THRESH, 32'h0000_03e8);
    repeat (100) @(posedge pclk);
    check({31'h0, quiet_active}, 32'h0);
    apb(1'b1, OFS_SCALE, 32'h0000_0450);
    repeat (100) @(posedge pclk);
    check({24'h0, amplitude}, 32'h34);
    // return by slowing down; the threshold stays put while in the other mode
    period <= 16'h0800;
    repeat (6400) @(posedge pclk);
    check({31'h0, quiet_active}, 32'h1);
    check({24'h0, amplitude}, 32'h50);
  endtask
  // mode-change interrupt: sticky, masked, cleared by writing one
  task automatic t_irq_mode();
    apb(1'b0, OFS_INT_STAT, 32'h0); check(rd & 32'h4, 32'h4);
    check({31'h0, irq}, 32'h0);
    apb(1'b1, OFS_INT_MASK, 32'h4);
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h1);
    apb(1'b1, OFS_INT_STAT, 32'h7);
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h0);
    apb(1'b1, OFS_INT_MASK, 32'h3);
  endtask
  // regulation from standstill, open-load flags and readback
  task automatic t_auto();
    // masks are lost in reset, so arm the open-load events again
    apb(1'b1, OFS_INT_MASK, 32'h3);
    apb(1'b1, OFS_SCALE, 32'h0000_0480);
    below_a <= 1'b1;
    apb(1'b1, OFS_CTRL, 32'h3);
    // motor stays still until the first regulation has settled
    repeat (128 * PWM_PERIOD_TB) @(posedge pclk);
    check({24'h0, amplitude}, 32'hff);
    apb(1'b0, OFS_STATUS, 32'h0); check(rd, 32'h0000_03ff);
    for (int i = 0; i < 4; i++) begin
      repeat (PWM_PERIOD_TB / 2) @(posedge pclk);
      check({30'h0, open_load_coil_a, open_load_coil_b}, 32'h2);
    end
    apb(1'b0, OFS_INT_STAT, 32'h0); check(rd & 32'h3, 32'h1);
    check({31'h0, irq}, 32'h1);
    apb(1'b1, OFS_INT_STAT, 32'h1);
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h0);
    period <= 16'h0010;
    run <= 1'b1;
    repeat (1100 * 16) @(posedge pclk);
    check({30'h0, open_load_coil_a, open_load_coil_b}, 32'h3);
    check({31'h0, irq}, 32'h1);
    below_a <= 1'b0;
    run <= 1'b0;
    repeat (3 * PWM_PERIOD_TB) @(posedge pclk);
    check({31'h0, amplitude < 8'hff}, 32'h1);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    do_reset();
    t_regs();
    t_velocity();
    t_irq_mode();
    // restart from zero velocity so regulation can start at standstill
    do_reset();
    t_regs();
    t_auto();
    finish_test();
  end
endmodule
